// ===== lsr_defs.vh
// Constants for the link status reporter: offsets, fields, resets
`ifndef LSR_DEFS_VH
`define LSR_DEFS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define LSR_ADDR_W         8
`define LSR_OFF_STATUS     8'h00
`define LSR_OFF_INT_STAT   8'h04
`define LSR_OFF_INT_MASK   8'h08
`define LSR_OFF_DERR_CNT   8'h0c
`define LSR_OFF_CTRL       8'h10

// ------------------------------------------------------------
// Status bus field positions
// ------------------------------------------------------------
`define LSR_ST_W           16
`define LSR_BIT_LINK_UP    0
`define LSR_BIT_CAT_ERR    1
`define LSR_BIT_LINK_ERR   2
`define LSR_BIT_DATA_ERR   3
`define LSR_BIT_OVERSIZE   4
`define LSR_BIT_MRST       5

// ------------------------------------------------------------
// Event, control fields and reset values
// ------------------------------------------------------------
`define LSR_EV_W           5
`define LSR_CTRL_RESTART   0
`define LSR_INT_MASK_RST   5'h00
`define LSR_CTRL_RST       1'h1
`define LSR_CNT_W          16

`endif

// ===== lsr_status.v
// Link status reporter: status bus, crossings, event interrupt regs
`timescale 1ns/1ps
`include "lsr_defs.vh"

module lsr_status
#(
  parameter PRIO_PORT_EN   = 1,
  parameter PRIO_SIZE_TEST = 1
)
(
  input  wire                   MCLK,
  input  wire                   RST_N,
  // Recovered-domain indications
  input  wire                   LINK_UP_RX,
  input  wire                   CAT_ERR_RX,
  input  wire                   LINK_ERR_TGL_RX,
  input  wire                   DATA_ERR_TGL_RX,
  // System-domain oversize detect pulse
  input  wire                   OVERSIZE_DET,
  // Master reset pin, asynchronous to MCLK
  input  wire                   MASTER_RESET_LOW,
  // Register port
  input  wire [`LSR_ADDR_W-1:0] REG_ADDR,
  input  wire [31:0]            REG_WDATA,
  input  wire                   REG_WR,
  input  wire                   REG_RD,
  output wire [31:0]            REG_RDATA,
  // Status and system outputs
  output wire [`LSR_ST_W-1:0]   STATUS_PORT,
  output wire                   LINK_RESTART,
  output wire                   IRQ
);

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------

  // Shared decode for reads and writes
  function hit;
    input [`LSR_ADDR_W-1:0] a;
    input [`LSR_ADDR_W-1:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // ------------------------------------------------------------
  // Level crossings
  // ------------------------------------------------------------
  reg  lu_s1_q;
  reg  lu_s2_q;
  reg  mr_s1_q;
  reg  mr_s2_q;

  // Only the second flop is read; the first may go metastable
  // link up sync
  always @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      lu_s1_q <= 1'b0;
      lu_s2_q <= 1'b0;
    end
    else
    begin
      lu_s1_q <= LINK_UP_RX;
      lu_s2_q <= lu_s1_q;
    end
  end

  always @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      mr_s1_q <= 1'b0;
      mr_s2_q <= 1'b0;
    end
    else
    begin
      mr_s1_q <= MASTER_RESET_LOW;
      mr_s2_q <= mr_s1_q;
    end
  end

  // ------------------------------------------------------------
  // Catastrophic error capture
  // ------------------------------------------------------------
  reg  cat_q;

  // The condition is permanent, so a rare metastable first cycle
  // settles before anyone can act on it.
  // single capture flop
  always @(posedge MCLK)
  begin
    if (!RST_N)
      cat_q <= 1'b0;
    else
      cat_q <= CAT_ERR_RX;
  end

  // ------------------------------------------------------------
  // Pulse crossings by toggle
  // ------------------------------------------------------------
  reg  [2:0] le_sync_q;
  reg  [2:0] de_sync_q;
  reg        le_pulse_q;
  reg        de_pulse_q;

  // Toggles from the recovered side; two toggles inside one
  // MCLK sample window cancel, which is why pulses may merge.
  // toggle handshake
  always @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      le_sync_q <= 3'h0;
      de_sync_q <= 3'h0;
    end
    else
    begin
      le_sync_q <= {le_sync_q[1:0], LINK_ERR_TGL_RX};
      de_sync_q <= {de_sync_q[1:0], DATA_ERR_TGL_RX};
    end
  end

  always @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      le_pulse_q <= 1'b0;
      de_pulse_q <= 1'b0;
    end
    else
    begin
      le_pulse_q <= le_sync_q[1] ^ le_sync_q[2];
      de_pulse_q <= de_sync_q[1] ^ de_sync_q[2];
    end
  end

  // ------------------------------------------------------------
  // Oversize discard indication
  // ------------------------------------------------------------
  localparam OV_EN = (PRIO_PORT_EN != 0) && (PRIO_SIZE_TEST != 0);
  reg  ov_q;

  always @(posedge MCLK)
  begin
    if (!RST_N)
      ov_q <= 1'b0;
    else
      ov_q <= OV_EN ? OVERSIZE_DET : 1'b0;
  end

  // ------------------------------------------------------------
  // Status bus assembly
  // ------------------------------------------------------------
  wire [`LSR_ST_W-1:0] status_w;

  // Every bit from a flop or tied to zero, so observers never see a glitch
  // local state only
  assign status_w = {10'h000, mr_s2_q, ov_q, de_pulse_q, le_pulse_q,
                     cat_q, lu_s2_q};
  assign STATUS_PORT = status_w;

  // ------------------------------------------------------------
  // Control register and link restart
  // ------------------------------------------------------------
  reg  ctrl_q;
  reg  restart_q;
  wire wr_ctrl;

  assign wr_ctrl = REG_WR && hit(REG_ADDR, `LSR_OFF_CTRL);

  // Restart enable; software may hold it off for debug
  always @(posedge MCLK)
  begin
    if (!RST_N)
      ctrl_q <= `LSR_CTRL_RST;
    else if (wr_ctrl)
      ctrl_q <= REG_WDATA[`LSR_CTRL_RESTART];
  end

  // Request only; the link itself is restarted outside
  // restart on link error
  always @(posedge MCLK)
  begin
    if (!RST_N)
      restart_q <= 1'b0;
    else
      restart_q <= ctrl_q & le_pulse_q;
  end

  assign LINK_RESTART = restart_q;

  // ------------------------------------------------------------
  // Data error counter
  // ------------------------------------------------------------
  reg  [`LSR_CNT_W-1:0] derr_cnt_q;
  reg  [`LSR_CNT_W-1:0] derr_cnt_d;
  wire                  wr_cnt;

  assign wr_cnt = REG_WR && hit(REG_ADDR, `LSR_OFF_DERR_CNT);

  // rate hint only
  // Saturating; an error in the clearing cycle counts as one
  always @*
  begin
    derr_cnt_d = derr_cnt_q;
    if (wr_cnt)
      derr_cnt_d = {{(`LSR_CNT_W-1){1'b0}}, de_pulse_q};
    else if (de_pulse_q && (derr_cnt_q != {`LSR_CNT_W{1'b1}}))
      derr_cnt_d = derr_cnt_q + 1'b1;
  end

  always @(posedge MCLK)
  begin
    if (!RST_N)
      derr_cnt_q <= {`LSR_CNT_W{1'b0}};
    else
      derr_cnt_q <= derr_cnt_d;
  end

  // ------------------------------------------------------------
  // Interrupt status and mask
  // ------------------------------------------------------------
  reg  [`LSR_EV_W-1:0] ist_q;
  reg  [`LSR_EV_W-1:0] ist_d;
  reg  [`LSR_EV_W-1:0] imask_q;
  reg                  lu_prev_q;
  reg                  cat_prev_q;
  wire [`LSR_EV_W-1:0] ev_w;
  wire                 wr_ist;
  wire                 wr_imask;

  assign wr_ist   = REG_WR && hit(REG_ADDR, `LSR_OFF_INT_STAT);
  assign wr_imask = REG_WR && hit(REG_ADDR, `LSR_OFF_INT_MASK);

  // Edge history for level-type events
  always @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      lu_prev_q  <= 1'b0;
      cat_prev_q <= 1'b0;
    end
    else
    begin
      lu_prev_q  <= lu_s2_q;
      cat_prev_q <= cat_q;
    end
  end

  // Events: link up rise, catastrophic rise, link, data, oversize
  assign ev_w = {ov_q, de_pulse_q, le_pulse_q,
                 cat_q & ~cat_prev_q, lu_s2_q & ~lu_prev_q};

  // Set beats a write-one-to-clear in the same cycle
  always @*
  begin
    ist_d = ist_q;
    if (wr_ist)
      ist_d = ist_q & ~REG_WDATA[`LSR_EV_W-1:0];
    ist_d = ist_d | ev_w;
  end

  always @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      ist_q   <= {`LSR_EV_W{1'b0}};
      imask_q <= `LSR_INT_MASK_RST;
    end
    else
    begin
      ist_q <= ist_d;
      if (wr_imask)
        imask_q <= REG_WDATA[`LSR_EV_W-1:0];
    end
  end

  // Level interrupt, high while any enabled bit is pending
  assign IRQ = |(ist_q & imask_q);

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  reg  [31:0] rdata_q;
  reg  [31:0] rdata_d;

  // Unmapped addresses read as zero
  always @*
  begin
    rdata_d = 32'h0000_0000;
    if (hit(REG_ADDR, `LSR_OFF_STATUS))
      rdata_d = {16'h0000, status_w};
    else if (hit(REG_ADDR, `LSR_OFF_INT_STAT))
      rdata_d = {27'h0000000, ist_q};
    else if (hit(REG_ADDR, `LSR_OFF_INT_MASK))
      rdata_d = {27'h0000000, imask_q};
    else if (hit(REG_ADDR, `LSR_OFF_DERR_CNT))
      rdata_d = {16'h0000, derr_cnt_q};
    else if (hit(REG_ADDR, `LSR_OFF_CTRL))
      rdata_d = {31'h00000000, ctrl_q};
  end

  // Zero otherwise, so a late sample cannot pick up stale data
  // Data held only in the cycle after the strobe
  always @(posedge MCLK)
  begin
    if (!RST_N)
      rdata_q <= 32'h0000_0000;
    else if (REG_RD)
      rdata_q <= rdata_d;
    else
      rdata_q <= 32'h0000_0000;
  end

  assign REG_RDATA = rdata_q;

endmodule

// ===== lsr_checker.sv
// Port assertions for the link status reporter
`timescale 1ns/1ps
module lsr_checker
(
  input wire        MCLK,
  input wire        RST_N,
  input wire        LINK_UP_RX,
  input wire        CAT_ERR_RX,
  input wire        LINK_ERR_TGL_RX,
  input wire        DATA_ERR_TGL_RX,
  input wire        OVERSIZE_DET,
  input wire        MASTER_RESET_LOW,
  input wire        REG_RD,
  input wire [31:0] REG_RDATA,
  input wire [15:0] STATUS_PORT,
  input wire        LINK_RESTART
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  chk_link_rise: assert property (
    $rose(LINK_UP_RX) ##0 LINK_UP_RX [*3] |-> ##[0:2] STATUS_PORT[0])
    else $error("link up did not follow input");
  chk_link_fall: assert property (
    $fell(LINK_UP_RX) ##0 !LINK_UP_RX [*3] |-> ##[0:2] !STATUS_PORT[0])
    else $error("link up did not drop");
  chk_cat_err: assert property (
    $past(RST_N) |-> STATUS_PORT[1] == $past(CAT_ERR_RX))
    else $error("catastrophic bit not one cycle behind");
  chk_link_err: assert property (
    $changed(LINK_ERR_TGL_RX)
      |-> ##[1:4] STATUS_PORT[2] ##1 !STATUS_PORT[2])
    else $error("link error pulse missing or long");
  chk_data_err: assert property (
    $changed(DATA_ERR_TGL_RX)
      |-> ##[1:4] STATUS_PORT[3] ##1 !STATUS_PORT[3])
    else $error("data error pulse missing or long");
  chk_oversize: assert property (
    $past(RST_N) |-> STATUS_PORT[4] == $past(OVERSIZE_DET))
    else $error("oversize pulse not one cycle behind");
  chk_mrst_echo: assert property (
    !MASTER_RESET_LOW [*4] |-> !STATUS_PORT[5])
    else $error("reset echo bit did not follow pin");
  chk_mrst_high: assert property (
    MASTER_RESET_LOW [*4] |-> STATUS_PORT[5])
    else $error("reset echo bit did not rise with pin");
  chk_reserved_zero: assert property (
    STATUS_PORT[15:6] == 10'h000)
    else $error("reserved status bits not zero");
  chk_restart_cause: assert property (
    LINK_RESTART |-> $past(STATUS_PORT[2]))
    else $error("restart without link error");
  chk_read_idle: assert property (
    !$past(REG_RD) |-> REG_RDATA == 32'h0)
    else $error("read data outside read cycle");
endmodule

// ===== lsr_monitor.sv
// Model of the system logic watching the status bus
`timescale 1ns/1ps
module lsr_monitor
(
  input  wire        clk,
  input  wire        rst_n,
  input  wire [15:0] status,
  output reg  [7:0]  derr_q,
  output reg  [7:0]  lerr_q
);
  // Error pulses tallied; merges make this a rate hint only
  // rate not count
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      derr_q <= 8'h00;
      lerr_q <= 8'h00;
    end
    else
    begin
      derr_q <= derr_q + {7'h00, status[3]};
      lerr_q <= lerr_q + {7'h00, status[2]};
    end
  end
endmodule

// ===== testbench.sv
// Self-checking bench for the link status reporter
`timescale 1ns/1ps
`include "lsr_defs.vh"
module testbench;
  reg         mclk = 1'b0;
  reg         rst_n = 1'b0;
  reg         link_up = 1'b0;
  reg         cat_err = 1'b0;
  reg         lerr_tgl = 1'b0;
  reg         derr_tgl = 1'b0;
  reg         ovs = 1'b0;
  reg         mrst_n = 1'b1;
  reg  [7:0]  addr = 8'h00;
  reg  [31:0] wdata = 32'h0;
  reg         wr = 1'b0;
  reg         rd = 1'b0;
  wire [31:0] rdata;
  wire [15:0] status;
  wire        restart;
  wire        irq;
  wire [7:0]  derr_seen;
  wire [7:0]  lerr_seen;
  integer     fail_count = 0;
  integer     comparisons = 0;
  integer     i;

  lsr_status i_lsr_status (.MCLK(mclk), .RST_N(rst_n),
    .LINK_UP_RX(link_up), .CAT_ERR_RX(cat_err),
    .LINK_ERR_TGL_RX(lerr_tgl), .DATA_ERR_TGL_RX(derr_tgl),
    .OVERSIZE_DET(ovs), .MASTER_RESET_LOW(mrst_n), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .STATUS_PORT(status), .LINK_RESTART(restart), .IRQ(irq));
  lsr_monitor i_lsr_monitor (.clk(mclk), .rst_n(rst_n),
    .status(status), .derr_q(derr_seen), .lerr_q(lerr_seen));

  // 25 MHz system clock
  always #20 mclk = ~mclk;

  task check(input [95:0] what, input [31:0] exp, input [31:0] got);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("unexpected %0s exp %h got %h", what, exp, got);
    end
  end
  endtask

  // Strobe dropped then one idle edge, so no double drive
  task wr_reg(input [7:0] a, input [31:0] d);
  begin
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  end
  endtask

  // Read data is valid only in the cycle after the strobe
  task rd_chk(input [95:0] what, input [7:0] a, input [31:0] exp);
  begin
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 check(what, exp, rdata);
    @(posedge mclk);
  end
  endtask

  task finish_test;
  begin
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask

  // Main sequence
  initial
  begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rd_chk("status", `LSR_OFF_STATUS, 32'h20);
    rd_chk("ctrl", `LSR_OFF_CTRL, 32'h1);
    rd_chk("mask", `LSR_OFF_INT_MASK, 32'h0);
    rd_chk("unmapped", 8'h20, 32'h0);
    wr_reg(`LSR_OFF_INT_MASK, 32'h1f);
    link_up <= 1'b1;
    repeat (5) @(posedge mclk);
    rd_chk("status", `LSR_OFF_STATUS, 32'h21);
    rd_chk("int stat", `LSR_OFF_INT_STAT, 32'h1);
    #1 check("irq", 32'h1, {31'h0, irq});
    wr_reg(`LSR_OFF_INT_STAT, 32'h1);
    rd_chk("int stat", `LSR_OFF_INT_STAT, 32'h0);
    #1 check("irq", 32'h0, {31'h0, irq});
    // Spaced data errors, each must give its own pulse
    for (i = 0; i < 3; i = i + 1)
    begin
      derr_tgl <= ~derr_tgl;
      repeat (5) @(posedge mclk);
    end
    check("derr seen", 32'h3, {24'h0, derr_seen});
    rd_chk("derr cnt", `LSR_OFF_DERR_CNT, 32'h3);
    wr_reg(`LSR_OFF_DERR_CNT, 32'h0);
    rd_chk("derr cnt", `LSR_OFF_DERR_CNT, 32'h0);
    // Link drops; wait bounded for the restart request
    lerr_tgl <= 1'b1;
    link_up <= 1'b0;
    i = 0;
    while (restart !== 1'b1 && i < 10)
    begin
      @(posedge mclk);
      #1 i = i + 1;
    end
    check("restart", 32'h1, {31'h0, restart});
    // A hang above skips the rest and goes straight to the report
    if (restart === 1'b1)
    begin
      repeat (3) @(posedge mclk);
      check("lerr seen", 32'h1, {24'h0, lerr_seen});
      ovs <= 1'b1;
      @(posedge mclk);
      ovs <= 1'b0;
      cat_err <= 1'b1;
      mrst_n <= 1'b0;
      repeat (5) @(posedge mclk);
      rd_chk("status", `LSR_OFF_STATUS, 32'h2);
      rd_chk("int stat", `LSR_OFF_INT_STAT, 32'h1e);
      #1 check("irq", 32'h1, {31'h0, irq});
      // Restart enable off: a further link error must not request one
      wr_reg(`LSR_OFF_CTRL, 32'h0);
      rd_chk("ctrl", `LSR_OFF_CTRL, 32'h0);
      lerr_tgl <= 1'b0;
      for (i = 0; i < 6; i = i + 1)
      begin
        @(posedge mclk);
        #1 check("restart off", 32'h0, {31'h0, restart});
      end
      check("lerr seen", 32'h2, {24'h0, lerr_seen});
    end
    finish_test;
  end
endmodule

bind lsr_status lsr_checker i_lsr_checker (.MCLK(MCLK), .RST_N(RST_N),
  .LINK_UP_RX(LINK_UP_RX), .CAT_ERR_RX(CAT_ERR_RX),
  .LINK_ERR_TGL_RX(LINK_ERR_TGL_RX), .DATA_ERR_TGL_RX(DATA_ERR_TGL_RX),
  .OVERSIZE_DET(OVERSIZE_DET), .MASTER_RESET_LOW(MASTER_RESET_LOW),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .STATUS_PORT(STATUS_PORT),
  .LINK_RESTART(LINK_RESTART));
